/* File: bfs_supervisor.sv */
// Backlight fault supervisor with AHB-Lite status and control registers
//
// Functional notes
// - Input undervoltage sets its flag, interrupts, drops to standby and restarts once cleared.
// - Input overvoltage sets its flag, interrupts, drops to standby and waits until cleared.
// - Core supply low sets its flag and interrupts without recovery, restarting once cleared.
// - Input overcurrent or bad pump level sets its flag, interrupts and recovers after 100 ms.
// - Missing pump parts set both pump flags, interrupt, disable the pump and keep running.
// - Loss of a sync clock seen at enable sets its flag, interrupts and falls back to internal.
// - After sync fallback, spread spectrum follows the level held on the sync input.
// - A failed configuration checksum sets its flag, interrupts and lets operation continue.
// - Feedback above the low overvoltage level sets a silent flag and pauses boost switching.
// - Feedback or discharge high overvoltage sets its flag, interrupts and recovers once low.
// - Feedback under the undervoltage level for 110 ms flags overcurrent and recovers.
// - A bad string strap sets a silent flag and selects four channels at 150 mA.
// - A bad mode strap sets a silent flag, selects phase-shift dimming and address 0x3a.
// - A bad boost or dimming frequency strap sets a silent flag and selects 400 kHz or 305 Hz for that one.
// - Recovery keeps the power stage off for 100 ms, then restarts only if enabled and lit.
// - Straps are judged only during initialization and the chosen setup is then kept.
`timescale 1ns/1ps
`include "bfs_map.svh"
module bfs_supervisor import bfs_pkg::*; #(
  parameter int RECOVERY_CYCLES = `BFS_RECOVERY_MS * `BFS_CLK_KHZ,
  parameter int OCP_CYCLES      = `BFS_OCP_MS * `BFS_CLK_KHZ,
  parameter int SYNC_GAP_CYCLES = `BFS_SYNC_GAP_CYCLES
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          ce,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic               hresp,
  output logic [31:0]        hrdata,
  input  wire bfs_fault_in_t fault_pins,
  input  wire bfs_strap_t    straps,
  input  wire logic          cfg_load_done,
  input  wire logic          cfg_crc_ok,
  output bfs_cfg_t           cfg,
  output bfs_ctrl_t          ctrl,
  output logic               irq
);
  localparam logic [13:0] IRQ_MASK = 14'h06ff;
  localparam int          TW       = 25;

  bfs_fault_in_t fp;
  bfs_state_t    state;
  bfs_state_t    next_state;
  logic [13:0]   flags;
  logic [13:0]   next_flags;
  logic [13:0]   fault_set;
  logic [13:0]   w1c;
  logic [31:0]   control;
  logic [TW-1:0] rec_cnt;
  logic [TW-1:0] ocp_cnt;
  logic [11:0]   gap_cnt;
  logic          sync_prev;
  logic          sync_armed;
  logic          sync_fallback;
  logic          pump_off;
  logic          wr_pend;
  logic [7:0]    wr_addr;

  // Comparators and pins cross into hclk before any logic sees them
  bfs_sync #(.WIDTH($bits(bfs_fault_in_t))) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ce       (ce),
    .async_in (fault_pins),
    .sync_out (fp)
  );

  // Address decode used by both the read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // Bus stalls while the clock enable is low, so no access is lost
  wire       addr_ok  = hsel && hready && htrans[1];
  wire       wr_start = addr_ok && hwrite;
  wire       rd_start = addr_ok && !hwrite;
  wire [7:0] a_addr   = {haddr[7:2], 2'b00};
  wire       wr_en    = wr_pend && ce;
  assign hreadyout = ce;
  assign hresp     = 1'b0;

  // Derived fault conditions
  wire [15:0] brightness = control[`BFS_CTRL_BRIGHT_MSB:`BFS_CTRL_BRIGHT_LSB];
  wire  in_run        = state == BFS_RUN;
  wire  ovp_high      = fp.fb_ovp_high || fp.discharge_ovp_high;
  wire  pump_lvl_trip = fp.pump_level_bad && !pump_off;
  wire  ocp_timeout   = ocp_cnt == TW'(OCP_CYCLES - 1);
  wire  rec_done      = rec_cnt == TW'(RECOVERY_CYCLES - 1);
  wire  sync_running  = gap_cnt < 12'(SYNC_GAP_CYCLES);
  wire  sync_lost     = in_run && sync_armed && !sync_running;
  wire  hold_standby  = fp.input_uv || fp.input_ov || fp.core_low;
  wire  recover_trip  = fp.input_oc || pump_lvl_trip || ovp_high || ocp_timeout;
  wire  start_ok      = fp.enable_pin && (brightness != 16'h0000) && !hold_standby
                        && !ovp_high;
  wire  init_end      = (state == BFS_INIT) && cfg_load_done;

  // Events that set each flag; boost faults count only while boost runs
  always_comb begin
    fault_set                   = '0;
    fault_set[BFS_F_IN_UV]      = fp.input_uv;
    fault_set[BFS_F_IN_OV]      = fp.input_ov;
    fault_set[BFS_F_CORE_LOW]   = fp.core_low;
    fault_set[BFS_F_IN_OC]      = fp.input_oc;
    fault_set[BFS_F_PUMP_LVL]   = fp.pump_level_bad || fp.pump_parts_missing;
    fault_set[BFS_F_PUMP_PARTS] = fp.pump_parts_missing;
    fault_set[BFS_F_SYNC_LOST]  = sync_lost;
    fault_set[BFS_F_CRC]        = init_end && !cfg_crc_ok;
    fault_set[BFS_F_OVP_LOW]    = in_run && fp.fb_ovp_low;
    fault_set[BFS_F_OVP_HIGH]   = in_run && ovp_high;
    fault_set[BFS_F_OCP]        = in_run && ocp_timeout;
    fault_set[BFS_F_STRING_RES] = init_end && !straps.string_ok;
    fault_set[BFS_F_MODE_RES]   = init_end && !straps.mode_ok;
    fault_set[BFS_F_FREQ_RES]   = init_end && !(straps.bfreq_ok && straps.dfreq_ok);
  end

  // Write-one-to-clear; a set in the same cycle wins over the clear
  assign w1c        = (wr_en && hit(wr_addr, `BFS_OFF_STATUS)) ? hwdata[13:0] : 14'h0000;
  assign next_flags = (flags & ~w1c) | fault_set;

  // Interrupt from flags that are allowed to raise it
  assign irq = |(flags & IRQ_MASK);

  // Mode sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      BFS_INIT: begin
        if (cfg_load_done) begin
          next_state = BFS_STANDBY;
        end
      end
      BFS_STANDBY: begin
        if (start_ok) begin
          next_state = BFS_RUN;
        end
      end
      BFS_RUN: begin
        if (in_run && recover_trip) begin
          next_state = BFS_RECOVER;
        end else if (hold_standby || !fp.enable_pin) begin
          next_state = BFS_STANDBY;
        end
      end
      BFS_RECOVER: begin
        if (rec_done && !ovp_high) begin
          next_state = BFS_STANDBY;
        end
      end
    endcase
  end

  // State and flag registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= BFS_INIT;
      flags <= 14'h0000;
    end else if (ce) begin
      state <= next_state;
      flags <= next_flags;
    end
  end

  // Recovery hold timer, started on entry and held at its end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rec_cnt <= '0;
    end else if (ce) begin
      if (state != BFS_RECOVER) begin
        rec_cnt <= '0;
      end else if (!rec_done) begin
        rec_cnt <= rec_cnt + TW'(1);
      end
    end
  end

  // Boost undervoltage persistence timer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ocp_cnt <= '0;
    end else if (ce) begin
      if (!in_run || !fp.fb_below_uvp || ocp_timeout) begin
        ocp_cnt <= '0;
      end else begin
        ocp_cnt <= ocp_cnt + TW'(1);
      end
    end
  end

  // Sync clock watchdog: cycles since the last rising edge, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_prev <= 1'b0;
      gap_cnt   <= 12'hfff;
    end else if (ce) begin
      sync_prev <= fp.boost_sync_input;
      if (fp.boost_sync_input && !sync_prev) begin
        gap_cnt <= 12'h000;
      end else if (gap_cnt != 12'hfff) begin
        gap_cnt <= gap_cnt + 12'h001;
      end
    end
  end

  // Sync use is decided at start; fallback lasts until the enable pin drops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_armed    <= 1'b0;
      sync_fallback <= 1'b0;
    end else if (ce) begin
      if (state == BFS_STANDBY && next_state == BFS_RUN) begin
        sync_armed <= sync_running;
      end else if (sync_lost) begin
        sync_armed    <= 1'b0;
        sync_fallback <= 1'b1;
      end
      if (!fp.enable_pin) begin
        sync_fallback <= 1'b0;
      end
    end
  end

  // Pump stays off once parts were found missing, until reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pump_off <= 1'b0;
    end else if (ce && fp.pump_parts_missing) begin
      pump_off <= 1'b1;
    end
  end

  // Straps are sampled once at the end of initialization only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= '{`BFS_STRING_DEFAULT, `BFS_MODE_PHASE_SHIFT, `BFS_I2C_ADDR_DEFAULT,
               `BFS_BFREQ_400KHZ, `BFS_DFREQ_305HZ};
    end else if (ce && init_end) begin
      cfg.string_cfg <= straps.string_ok ? straps.string_code : `BFS_STRING_DEFAULT;
      cfg.mode_cfg   <= straps.mode_ok ? straps.mode_code : `BFS_MODE_PHASE_SHIFT;
      cfg.i2c_addr   <= straps.mode_ok ? straps.mode_addr : `BFS_I2C_ADDR_DEFAULT;
      cfg.bfreq_cfg  <= straps.bfreq_ok ? straps.bfreq_code : `BFS_BFREQ_400KHZ;
      cfg.dfreq_cfg  <= straps.dfreq_ok ? straps.dfreq_code : `BFS_DFREQ_305HZ;
    end
  end

  // Power stage enables; switch, boost and driver enables are off outside run, pump and clock selects are not
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= '0;
    end else if (ce) begin
      ctrl.power_switch_en   <= next_state == BFS_RUN;
      ctrl.boost_en          <= next_state == BFS_RUN;
      ctrl.boost_switch_en   <= next_state == BFS_RUN && !fp.fb_ovp_low;
      ctrl.led_drivers_en    <= next_state == BFS_RUN;
      ctrl.pump_en           <= !pump_off && !fp.pump_parts_missing;
      ctrl.internal_freq_sel <= !sync_armed || sync_lost;
      ctrl.spread_en         <= sync_fallback ? fp.boost_sync_input
                                              : control[`BFS_CTRL_SPREAD_BIT];
    end
  end

  // AHB data phase bookkeeping and the control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      control <= `BFS_CTRL_RESET;
    end else if (ce) begin
      wr_pend <= wr_start;
      wr_addr <= a_addr;
      if (wr_en && hit(wr_addr, `BFS_OFF_CONTROL)) begin
        control <= hwdata & 32'h0001_ffff;
      end
    end
  end

  // Read data is captured in the address phase; unmapped words read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ce && rd_start) begin
      if (hit(a_addr, `BFS_OFF_STATUS)) begin
        hrdata <= {18'h00000, flags};
      end else if (hit(a_addr, `BFS_OFF_CONTROL)) begin
        hrdata <= control;
      end else if (hit(a_addr, `BFS_OFF_CONFIG)) begin
        hrdata <= {12'h000, cfg};
      end else if (hit(a_addr, `BFS_OFF_STATE)) begin
        hrdata <= {23'h000000, ctrl, state};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end
endmodule // bfs_supervisor

/* File: bfs_map.svh */
// Offsets, field positions, reset values and timing figures of the fault supervisor
`ifndef BFS_MAP_SVH
`define BFS_MAP_SVH
`define BFS_OFF_STATUS        8'h00
`define BFS_OFF_CONTROL       8'h04
`define BFS_OFF_CONFIG        8'h08
`define BFS_OFF_STATE         8'h0c
`define BFS_CTRL_BRIGHT_LSB   0
`define BFS_CTRL_BRIGHT_MSB   15
`define BFS_CTRL_SPREAD_BIT   16
`define BFS_CTRL_RESET        32'h0000_0000
`define BFS_CLK_KHZ           200000
`define BFS_RECOVERY_MS       100
`define BFS_OCP_MS            110
`define BFS_SYNC_MIN_KHZ      75
`define BFS_SYNC_GAP_CYCLES   (`BFS_CLK_KHZ / `BFS_SYNC_MIN_KHZ)
`define BFS_STRING_DEFAULT    3'h0
`define BFS_MODE_PHASE_SHIFT  2'h0
`define BFS_I2C_ADDR_DEFAULT  7'h3a
`define BFS_BFREQ_400KHZ      4'h0
`define BFS_DFREQ_305HZ       4'h0
`endif

/* File: bfs_pkg.sv */
// Types shared by the fault supervisor modules
package bfs_pkg;
  // Flag positions in the status word
  typedef enum logic [3:0] {
    BFS_F_IN_UV = 4'h0, BFS_F_IN_OV = 4'h1, BFS_F_CORE_LOW = 4'h2, BFS_F_IN_OC = 4'h3,
    BFS_F_PUMP_LVL = 4'h4, BFS_F_PUMP_PARTS = 4'h5, BFS_F_SYNC_LOST = 4'h6,
    BFS_F_CRC = 4'h7, BFS_F_OVP_LOW = 4'h8, BFS_F_OVP_HIGH = 4'h9, BFS_F_OCP = 4'ha,
    BFS_F_STRING_RES = 4'hb, BFS_F_MODE_RES = 4'hc, BFS_F_FREQ_RES = 4'hd
  } bfs_flag_t;
  // Gray codes along init, standby, run, recovery
  typedef enum logic [1:0] {
    BFS_INIT = 2'b00, BFS_STANDBY = 2'b01, BFS_RUN = 2'b11, BFS_RECOVER = 2'b10
  } bfs_state_t;
  // Comparator and pin levels, all asynchronous to hclk
  typedef struct packed {
    logic input_uv;
    logic input_ov;
    logic core_low;
    logic input_oc;
    logic pump_level_bad;
    logic pump_parts_missing;
    logic fb_ovp_low;
    logic fb_ovp_high;
    logic discharge_ovp_high;
    logic fb_below_uvp;
    logic boost_sync_input;
    logic enable_pin;
  } bfs_fault_in_t;
  // Strap detector results, valid while initialization runs
  typedef struct packed {
    logic       string_ok;
    logic [2:0] string_code;
    logic       mode_ok;
    logic [1:0] mode_code;
    logic [6:0] mode_addr;
    logic       bfreq_ok;
    logic [3:0] bfreq_code;
    logic       dfreq_ok;
    logic [3:0] dfreq_code;
  } bfs_strap_t;
  // Configuration kept from initialization
  typedef struct packed {
    logic [2:0] string_cfg;
    logic [1:0] mode_cfg;
    logic [6:0] i2c_addr;
    logic [3:0] bfreq_cfg;
    logic [3:0] dfreq_cfg;
  } bfs_cfg_t;
  // Power stage enables
  typedef struct packed {
    logic power_switch_en;
    logic boost_en;
    logic boost_switch_en;
    logic led_drivers_en;
    logic pump_en;
    logic internal_freq_sel;
    logic spread_en;
  } bfs_ctrl_t;
endpackage

/* File: bfs_sync.sv */
// Two-stage synchroniser for a bus of asynchronous levels
`timescale 1ns/1ps
module bfs_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1   <= '0;
      sync_out <= '0;
    end else if (ce) begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // bfs_sync

/* File: bfs_supervisor_asserts.sv */
// Port-level assertions for the backlight fault supervisor
`timescale 1ns/1ps
module bfs_supervisor_asserts import bfs_pkg::*; (
  input wire logic          hclk,
  input wire logic          hresetn,
  input wire bfs_fault_in_t fault_pins,
  input wire logic          cfg_load_done,
  input wire bfs_cfg_t      cfg,
  input wire bfs_ctrl_t     ctrl,
  input wire logic          irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Five samples cover two synchroniser flops plus the ctrl or flag register
  uv_standby_a: assert property (fault_pins.input_uv [*5] |-> !ctrl.boost_en)
    else $error("boost still on under input undervoltage");
  uv_irq_a: assert property (fault_pins.input_uv [*5] |-> irq)
    else $error("no interrupt on input undervoltage");
  ov_off_a: assert property (fault_pins.input_ov [*5] |-> !ctrl.power_switch_en)
    else $error("power switch on under input overvoltage");
  core_irq_a: assert property (fault_pins.core_low [*5] |-> irq && !ctrl.boost_en)
    else $error("core supply low not handled");
  oc_off_a: assert property (fault_pins.input_oc [*5] |-> !ctrl.led_drivers_en)
    else $error("drivers on under input overcurrent");
  pump_off_a: assert property (fault_pins.pump_parts_missing [*5] |-> !ctrl.pump_en [*8])
    else $error("pump not held off with parts missing");
  ovp_low_a: assert property (fault_pins.fb_ovp_low [*5] |-> !ctrl.boost_switch_en)
    else $error("boost switching during low overvoltage");
  ovph_off_a: assert property ((fault_pins.fb_ovp_high || fault_pins.discharge_ovp_high) [*5]
    |-> !ctrl.boost_en)
    else $error("boost on during high overvoltage");
  // Pin to enable spans two synchroniser flops and the ctrl register
  restart_en_a: assert property ($rose(ctrl.power_switch_en) |-> $past(fault_pins.enable_pin, 3))
    else $error("restart without enable pin");
  // Once running, or before load ends, the kept setup must not move
  cfg_hold_a: assert property ((ctrl.power_switch_en || !cfg_load_done) |-> $stable(cfg))
    else $error("configuration changed after initialization");
  irq_seen_c: cover property ($rose(irq));
  pump_cut_c: cover property ($fell(ctrl.pump_en));
  fallback_c: cover property ($rose(ctrl.internal_freq_sel));
endmodule // bfs_supervisor_asserts

/* File: bfs_fault_model.sv */
// Far-side model: fault comparator levels and an external boost sync clock
`timescale 1ns/1ps
module bfs_fault_model import bfs_pkg::*; (
  input  wire logic          hclk,
  input  wire bfs_fault_in_t lvl,
  input  wire logic          sync_run,
  output bfs_fault_in_t      fault_pins
);
  logic [1:0] div = 2'h0;
  logic       sclk = 1'b0;
  // Sync clock of eight hclk periods, far faster than the loss gap
  always @(posedge hclk) begin
    div <= div + 2'h1;
    if (div == 2'h3) sclk <= ~sclk;
  end
  // When stopped the sync pin rests at the level the bench holds
  always_comb begin
    fault_pins = lvl;
    if (sync_run) fault_pins.boost_sync_input = sclk;
  end
endmodule // bfs_fault_model

/* File: test_backlight_fault_supervisor.sv */
// Self-checking bench for the backlight fault supervisor
`timescale 1ns/1ps
`include "bfs_map.svh"
module test_backlight_fault_supervisor import bfs_pkg::*;;
  localparam int REC = 50, OCP = 40, GAP = 20;
  localparam logic [31:0] A_SS = {24'h0, `BFS_OFF_STATUS}, A_CT = {24'h0, `BFS_OFF_CONTROL};
  localparam logic [31:0] A_CF = {24'h0, `BFS_OFF_CONFIG}, A_ST = {24'h0, `BFS_OFF_STATE};
  logic          hclk = 0, hresetn = 0, ce = 1, hsel = 0, hwrite = 0, sync_run = 0;
  logic          cfg_load_done = 0, cfg_crc_ok = 0, hreadyout, hresp, irq;
  logic [31:0]   haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0]    htrans = 0;
  logic [2:0]    hsize = 3'h2;
  bfs_fault_in_t lvl = '0, fault_pins;
  bfs_strap_t    straps = {1'b0, 3'h5, 1'b0, 2'h2, 7'h11, 1'b0, 4'h7, 1'b1, 4'h9};
  bfs_cfg_t      cfg;
  bfs_ctrl_t     ctrl;
  int            failures = 0, cmp_count = 0, cyc = 0, t0, i;
  // Clock and a free cycle count for timing checks
  always #2.5 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;
  bfs_supervisor #(.RECOVERY_CYCLES(REC), .OCP_CYCLES(OCP), .SYNC_GAP_CYCLES(GAP))
    bfs_supervisor_inst (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fault_pins(fault_pins),
    .straps(straps), .cfg_load_done(cfg_load_done), .cfg_crc_ok(cfg_crc_ok), .cfg(cfg),
    .ctrl(ctrl), .irq(irq));
  bfs_fault_model bfs_fault_model_inst (.hclk(hclk), .lvl(lvl), .sync_run(sync_run),
    .fault_pins(fault_pins));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // One single AHB-Lite transfer; read data lands in q
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1; htrans <= 2'b10; hwrite <= w; haddr <= a;
    @(posedge hclk); while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 0; htrans <= 2'b00; hwdata <= d;
    @(posedge hclk); while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task automatic wst(input logic [1:0] s, input int n);
    int k;
    bus(0, A_ST, 0);
    for (k = 0; k < n && q[1:0] !== s; k++) bus(0, A_ST, 0);
    chk("state", {30'h0, s}, {30'h0, q[1:0]});
  endtask
  task automatic t_init;
    bus(0, A_CF, 0); chk("config", 32'h00003a09, q);
    chk("cfg port", 32'h00003a09, {12'h000, cfg});
    bus(0, A_SS, 0); chk("status", 32'h00003880, q);
    chk("irq crc", 1, irq);
    bus(1, A_SS, 32'h80); bus(0, A_SS, 0); chk("strap flags", 32'h3800, q);
    chk("irq quiet", 0, irq);
  endtask
  task automatic t_start;
    bus(1, A_CT, 32'h1); lvl.enable_pin <= 1;
    wst(2'b11, 20); chk("ctrl run", 7'h7e, ctrl);
    straps <= {1'b1, 3'h1, 1'b1, 2'h1, 7'h22, 1'b1, 4'h1, 1'b1, 4'h1};
    repeat (5) @(posedge hclk);
    bus(0, A_CF, 0); chk("config kept", 32'h3a09, q);
  endtask
  // Input and core supply faults drop to standby, no timed recovery
  task automatic t_supply;
    for (i = 0; i < 3; i++) begin
      lvl[11-i] <= 1;
      wst(2'b01, 20); chk("power off", 0, ctrl.power_switch_en);
      chk("irq supply", 1, irq);
      lvl[11-i] <= 0; repeat (4) @(posedge hclk);
      bus(0, A_SS, 0); chk("flag held", 32'h3800 | (32'h1 << i), q);
      bus(1, A_SS, 32'h7); wst(2'b11, 20); chk("irq cleared", 0, irq);
    end
  endtask
  task automatic t_recover;
    for (i = 0; i < 2; i++) begin
      lvl[8-i] <= 1; wst(2'b10, 20); t0 = cyc; lvl[8-i] <= 0;
      chk("stage off", 0, {ctrl.power_switch_en, ctrl.boost_en, ctrl.led_drivers_en});
      wst(2'b11, 60);
      chk("recover span", 1, cyc - t0 >= REC - 5 && cyc - t0 <= REC + 10);
      bus(0, A_SS, 0); chk("oc flag", 32'h3800 | (32'h8 << i), q);
      bus(1, A_SS, 32'h18);
    end
  endtask
  task automatic t_ovph;
    for (i = 0; i < 2; i++) begin
      lvl[3+i] <= 1; wst(2'b10, 20); chk("irq ovph", 1, irq);
      repeat (REC + 10) @(posedge hclk);
      bus(0, A_ST, 0); chk("held in recovery", 2'b10, q[1:0]);
      lvl[3+i] <= 0; wst(2'b11, 60);
      bus(0, A_SS, 0); chk("ovph flag", 32'h3a00, q);
      bus(1, A_SS, 32'h200);
    end
  endtask
  task automatic t_ovpl;
    lvl.fb_ovp_low <= 1; repeat (6) @(posedge hclk);
    chk("ovpl stage", 2'b01, {ctrl.boost_switch_en, ctrl.led_drivers_en});
    chk("irq ovpl", 0, irq);
    bus(0, A_SS, 0); chk("ovpl flag", 32'h3900, q);
    lvl.fb_ovp_low <= 0; repeat (6) @(posedge hclk);
    chk("boost resumes", 1, ctrl.boost_switch_en);
    bus(1, A_SS, 32'h100);
  endtask
  task automatic t_ocp;
    lvl.fb_below_uvp <= 1; repeat (OCP - 10) @(posedge hclk); lvl.fb_below_uvp <= 0;
    bus(0, A_SS, 0); chk("short dip", 32'h3800, q);
    lvl.fb_below_uvp <= 1; t0 = cyc; wst(2'b10, OCP);
    chk("ocp span", 1, cyc - t0 >= OCP && cyc - t0 <= OCP + 12);
    lvl.fb_below_uvp <= 0; wst(2'b11, 60);
    bus(0, A_SS, 0); chk("ocp flag", 32'h3c00, q);
    bus(1, A_SS, 32'h400);
  endtask
  task automatic t_sync;
    lvl.enable_pin <= 0; wst(2'b01, 20); sync_run <= 1;
    repeat (30) @(posedge hclk); lvl.enable_pin <= 1; wst(2'b11, 20);
    chk("external freq", 0, ctrl.internal_freq_sel);
    lvl.boost_sync_input <= 1; sync_run <= 0; repeat (GAP + 10) @(posedge hclk);
    bus(0, A_SS, 0); chk("sync flag", 32'h3840, q);
    chk("fallback high", 3'b111, {irq, ctrl.internal_freq_sel, ctrl.spread_en});
    lvl.boost_sync_input <= 0; repeat (6) @(posedge hclk);
    chk("spread low", 0, ctrl.spread_en);
    bus(1, A_SS, 32'h40);
  endtask
  task automatic t_pump;
    lvl.pump_parts_missing <= 1; repeat (8) @(posedge hclk);
    bus(0, A_SS, 0); chk("pump flags", 32'h3830, q);
    chk("pump off", 2'b01, {ctrl.pump_en, ctrl.led_drivers_en});
    bus(0, A_ST, 0); chk("keeps running", 2'b11, q[1:0]);
    bus(1, 32'h10, 32'hffff); bus(0, 32'h10, 0); chk("unmapped", 0, q);
    bus(0, A_CT, 0); chk("control", 32'h1, q);
    chk("hresp okay", 0, hresp);
  endtask
  task automatic test_done;
    $display("Comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Main sequence after a ten cycle reset
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1; cfg_load_done <= 1;
    t_init; t_start; t_supply; t_recover; t_ovph; t_ovpl; t_ocp; t_sync; t_pump;
    test_done;
  end
  // Watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    test_done;
  end
endmodule // test_backlight_fault_supervisor
bind bfs_supervisor bfs_supervisor_asserts bfs_supervisor_asserts_inst (.hclk(hclk),
  .hresetn(hresetn), .fault_pins(fault_pins), .cfg_load_done(cfg_load_done), .cfg(cfg),
  .ctrl(ctrl), .irq(irq));
